// file: verilog/crfp_pkg.sv
// Purpose: Shared constants and types for the core register file and helper primitives
// Assumes: 32-bit datapath, five-bit mode field
// Notes: Mode encodings follow the classic five-bit mode field values
package crfp_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned SPEC_W = 4;
    localparam int unsigned PHYS_REGS = 31;
    localparam int unsigned PHYS_W = 5;
    localparam logic [3:0] REG_SP = 4'hd;
    localparam logic [3:0] REG_LINK = 4'he;
    localparam logic [3:0] REG_PC = 4'hf;
    localparam logic [3:0] REG_FAST_LO = 4'h8;
    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    localparam logic [31:0] PC_AHEAD = 32'h0000_0008;
    localparam logic [31:0] INSN_BYTES = 32'h0000_0004;
    localparam logic [31:0] PC_ALIGN_MASK = 32'hffff_fffc;
    localparam logic [2:0] SIZE_BYTE = 3'h1;
    localparam logic [2:0] SIZE_HALF = 3'h2;
    localparam logic [2:0] SIZE_WORD = 3'h4;
    localparam logic [4:0] PHYS_FAST_BASE = 5'h0f;
    // Fast bank fills slots 15..21, so the other exception banks start above it
    localparam logic [4:0] PHYS_EXC_BASE = 5'h16;
    localparam int unsigned SHIFT_W = 5;

    typedef enum logic [4:0] {
        CRFP_MODE_USER = 5'h10,
        CRFP_MODE_FAST = 5'h11,
        CRFP_MODE_IRQ = 5'h12,
        CRFP_MODE_SUPV = 5'h13,
        CRFP_MODE_ABORT = 5'h17,
        CRFP_MODE_UNDEF = 5'h1b,
        CRFP_MODE_SYS = 5'h1f
    } crfp_mode_t;

    typedef enum logic [1:0] {
        CRFP_SH_LSL = 2'h0,
        CRFP_SH_LSR = 2'h1,
        CRFP_SH_ASR = 2'h2,
        CRFP_SH_ROR = 2'h3
    } crfp_shift_t;
endpackage

// file: verilog/crfp_primitives.sv
// Purpose: Combinational helper primitives for the execute datapath
// Assumes: Operands are 32-bit; shift amount 0..31
// Notes: No state; every output is a pure function of the inputs
`timescale 1ns/10ps
module crfp_primitives (
    input wire logic [31:0] shift_val_i,
    input wire logic [4:0] shift_amt_i,
    input wire logic [1:0] shift_op_i,
    input wire logic [31:0] ovf_a_i,
    input wire logic [31:0] ovf_b_i,
    input wire logic [31:0] ovf_res_i,
    input wire logic ovf_sub_i,
    input wire logic [31:0] pop_field_i,
    output logic [31:0] shift_res_o,
    output logic ovf_o,
    output logic [5:0] pop_count_o
);
    function automatic logic [5:0] population_count(input logic [31:0] f);
        logic [5:0] n;
        n = 6'h00;
        for (int i = 0; i < 32; i++) begin
            n = n + {5'h00, f[i]};
        end
        return n;
    endfunction

    wire [31:0] lsl_w = shift_val_i << shift_amt_i;
    wire [31:0] lsr_w = shift_val_i >> shift_amt_i;
    wire [31:0] asr_w = $unsigned($signed(shift_val_i) >>> shift_amt_i);
    wire [63:0] dbl_w = {shift_val_i, shift_val_i} >> shift_amt_i;
    wire [31:0] ror_w = dbl_w[31:0];
    wire add_ovf_w = (ovf_a_i[31] == ovf_b_i[31]) && (ovf_res_i[31] != ovf_a_i[31]);
    wire sub_ovf_w = (ovf_a_i[31] != ovf_b_i[31]) && (ovf_res_i[31] != ovf_a_i[31]);

    assign shift_res_o = (shift_op_i == crfp_pkg::CRFP_SH_LSL) ? lsl_w :
                         (shift_op_i == crfp_pkg::CRFP_SH_LSR) ? lsr_w :
                         (shift_op_i == crfp_pkg::CRFP_SH_ASR) ? asr_w : ror_w;
    assign ovf_o = ovf_sub_i ? sub_ovf_w : add_ovf_w;
    assign pop_count_o = population_count(pop_field_i);
endmodule

// file: verilog/crfp_core.sv
// Purpose: Banked integer register file with program counter, link and helper primitives
// Assumes: Decode/execute datapath drives one instruction per step enable
// Notes: Unpredictable cases resolve to defined values and never stall
//
// How it works
// - Thirty-one 32-bit physical registers, sixteen visible at a time.
// - Each read and write specifier can reach all sixteen visible registers.
// - Reading register 15 returns current instruction address plus eight.
// - Program counter keeps 30 bits; its low two bits read as zero.
// - Branch-with-link writes the next instruction address into register 14.
// - Registers 0 to 13 are plain storage with no hardware function.
// - User mode cannot change mode except by taking an exception.
// - Saved status predicate true except in user and system modes.
// - Privilege predicate true in every mode but user.
// - Size codes 1, 2, 4; halfword drops address bit 0, word bits 1:0.
// - Byte and halfword loads zero-extend unless sign extension is asked.
// - Add overflow when operand signs match and result sign differs.
// - Subtract overflow when operand signs differ and result differs from first.
// - Logical shifts fill vacated positions with zeros.
// - Rotate right reinserts bits shifted out at the top.
// - Sign extension replicates the sign bit to 32 bits; fields unsigned by default.
// - Population count returns the number of set bits.
// - Read-as-zero fields always read zero regardless of writes.
// - Unpredictable operations never stall, hang or bypass protection.
// - Each exception mode has private copies of registers 13 and 14.
// - Fast interrupt mode also banks registers 8 to 12.
// - System mode is privileged but uses the user register set.
`timescale 1ns/10ps
module crfp_core (
    input wire logic CORE_CLK_I,
    input wire logic SRST_I,
    input wire logic STEP_I,
    input wire logic [3:0] RD_A_SEL_I,
    input wire logic [3:0] RD_B_SEL_I,
    output logic [31:0] RD_A_DATA_O,
    output logic [31:0] RD_B_DATA_O,
    input wire logic WR_EN_I,
    input wire logic [3:0] WR_SEL_I,
    input wire logic [31:0] WR_DATA_I,
    input wire logic BRANCH_WITH_LINK_I,
    input wire logic BRANCH_TAKEN_I,
    input wire logic [31:0] BRANCH_TARGET_I,
    input wire logic MODE_WR_I,
    input wire logic [4:0] MODE_NEW_I,
    input wire logic EXC_TAKE_I,
    input wire logic [4:0] EXC_MODE_I,
    input wire logic [31:0] EXC_VECTOR_I,
    output logic [31:0] PROGRAM_COUNTER_O,
    output logic [4:0] MODE_O,
    output logic MODE_HAS_SAVED_STATUS_O,
    output logic IS_PRIVILEGED_MODE_O,
    input wire logic [31:0] MEM_ADDR_I,
    input wire logic [2:0] MEM_SIZE_I,
    output logic [31:0] MEM_ADDR_ALIGNED_O,
    input wire logic [31:0] LOAD_RAW_I,
    input wire logic LOAD_SIGNED_I,
    output logic [31:0] LOAD_DATA_O,
    input wire logic [31:0] SEXT_ARG_I,
    input wire logic [4:0] SEXT_MSB_I,
    output logic [31:0] SIGN_EXTEND_32_O,
    input wire logic [31:0] FIELD_VAL_I,
    input wire logic [31:0] READ_AS_ZERO_FIELD_MASK_I,
    output logic [31:0] FIELD_READ_O,
    input wire logic [31:0] SHIFT_VAL_I,
    input wire logic [4:0] SHIFT_AMT_I,
    input wire logic [1:0] SHIFT_OP_I,
    output logic [31:0] SHIFT_RES_O,
    input wire logic [31:0] OVF_A_I,
    input wire logic [31:0] OVF_B_I,
    input wire logic [31:0] OVF_RES_I,
    input wire logic OVF_SUB_I,
    output logic SIGNED_OVERFLOW_DETECT_O,
    input wire logic [31:0] POP_FIELD_I,
    output logic [5:0] POPULATION_COUNT_O
);
    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Mode predicates and bank mapping
    function automatic logic mode_has_saved_status(input logic [4:0] m);
        return (m != crfp_pkg::CRFP_MODE_USER) && (m != crfp_pkg::CRFP_MODE_SYS);
    endfunction

    function automatic logic is_privileged_mode(input logic [4:0] m);
        return m != crfp_pkg::CRFP_MODE_USER;
    endfunction

    function automatic logic mode_legal(input logic [4:0] m);
        return (m == crfp_pkg::CRFP_MODE_USER) || (m == crfp_pkg::CRFP_MODE_FAST) ||
               (m == crfp_pkg::CRFP_MODE_IRQ) || (m == crfp_pkg::CRFP_MODE_SUPV) ||
               (m == crfp_pkg::CRFP_MODE_ABORT) || (m == crfp_pkg::CRFP_MODE_UNDEF) ||
               (m == crfp_pkg::CRFP_MODE_SYS);
    endfunction

    // Exception bank offset: irq 0, supv 2, abort 4, undef 6; each offset holds 13, the next slot 14
    function automatic logic [4:0] exc_slot(input logic [4:0] m);
        logic [4:0] s;
        s = 5'h00;
        if (m == crfp_pkg::CRFP_MODE_SUPV) begin
            s = 5'h02;
        end else if (m == crfp_pkg::CRFP_MODE_ABORT) begin
            s = 5'h04;
        end else if (m == crfp_pkg::CRFP_MODE_UNDEF) begin
            s = 5'h06;
        end
        return s;
    endfunction

    // Physical map: 0..14 user r0..r14, 15..21 fast r8..r14, 22..29 other exception r13/r14
    // Only 30 slots hold data; the program counter is the thirty-first register
    function automatic logic [4:0] phys_index(input logic [4:0] m, input logic [3:0] r);
        logic [4:0] p;
        p = {1'b0, r};
        if (m == crfp_pkg::CRFP_MODE_FAST && r >= crfp_pkg::REG_FAST_LO) begin
            p = crfp_pkg::PHYS_FAST_BASE + {1'b0, r - crfp_pkg::REG_FAST_LO};
        end else if (mode_has_saved_status(m) && m != crfp_pkg::CRFP_MODE_FAST && r >= crfp_pkg::REG_SP) begin
            p = crfp_pkg::PHYS_EXC_BASE + exc_slot(m) + {4'h0, r == crfp_pkg::REG_LINK};
        end
        return p;
    endfunction

    function automatic logic [31:0] sign_extend_32(input logic [31:0] a, input logic [4:0] msb);
        logic [31:0] keep;
        keep = 32'hffff_ffff >> (5'h1f - msb);
        return a[msb] ? (a | ~keep) : (a & keep);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // State
    logic [31:0] regs [0:29];
    logic [31:0] pc;
    logic [4:0] mode;

    wire [4:0] rd_a_phys = phys_index(mode, RD_A_SEL_I);
    wire [4:0] rd_b_phys = phys_index(mode, RD_B_SEL_I);
    wire [4:0] wr_phys = phys_index(mode, WR_SEL_I);
    wire [4:0] link_phys = phys_index(mode, crfp_pkg::REG_LINK);
    wire [31:0] pc_read = pc + crfp_pkg::PC_AHEAD;
    wire [31:0] pc_next_seq = pc + crfp_pkg::INSN_BYTES;
    wire wr_to_pc = WR_EN_I && (WR_SEL_I == crfp_pkg::REG_PC);
    wire wr_to_file = WR_EN_I && (WR_SEL_I != crfp_pkg::REG_PC);
    // Guarded mode write: user mode ignores it, an illegal code is dropped rather than trapping
    wire mode_change_ok = MODE_WR_I && is_privileged_mode(mode) && mode_legal(MODE_NEW_I);
    wire exc_ok = EXC_TAKE_I && mode_legal(EXC_MODE_I) && (EXC_MODE_I != crfp_pkg::CRFP_MODE_USER) &&
                  (EXC_MODE_I != crfp_pkg::CRFP_MODE_SYS);

    wire [31:0] next_pc = exc_ok ? EXC_VECTOR_I :
                          BRANCH_TAKEN_I ? BRANCH_TARGET_I :
                          wr_to_pc ? WR_DATA_I : pc_next_seq;
    wire [4:0] next_mode = exc_ok ? EXC_MODE_I : mode_change_ok ? MODE_NEW_I : mode;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Sequential update; a link write takes priority over a data write to the same slot
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            pc <= crfp_pkg::PC_RESET;
            mode <= crfp_pkg::CRFP_MODE_SUPV;
        end else if (STEP_I) begin
            pc <= next_pc & crfp_pkg::PC_ALIGN_MASK;
            mode <= next_mode;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (STEP_I && !SRST_I) begin
            if (wr_to_file && !(BRANCH_WITH_LINK_I && wr_phys == link_phys)) begin
                regs[wr_phys] <= WR_DATA_I;
            end
            if (BRANCH_WITH_LINK_I && !exc_ok) begin
                regs[link_phys] <= pc_next_seq;
            end
        end
    end

    assign RD_A_DATA_O = (RD_A_SEL_I == crfp_pkg::REG_PC) ? pc_read : regs[rd_a_phys];
    assign RD_B_DATA_O = (RD_B_SEL_I == crfp_pkg::REG_PC) ? pc_read : regs[rd_b_phys];
    assign PROGRAM_COUNTER_O = pc;
    assign MODE_O = mode;
    assign MODE_HAS_SAVED_STATUS_O = mode_has_saved_status(mode);
    assign IS_PRIVILEGED_MODE_O = is_privileged_mode(mode);

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Memory size and load extension; an unknown size code falls back to word alignment
    wire [31:0] addr_half = {MEM_ADDR_I[31:1], 1'b0};
    wire [31:0] addr_word = {MEM_ADDR_I[31:2], 2'b00};
    assign MEM_ADDR_ALIGNED_O = (MEM_SIZE_I == crfp_pkg::SIZE_BYTE) ? MEM_ADDR_I :
                                (MEM_SIZE_I == crfp_pkg::SIZE_HALF) ? addr_half : addr_word;
    wire [31:0] load_byte = LOAD_SIGNED_I ? sign_extend_32(LOAD_RAW_I, 5'h07) : {24'h000000, LOAD_RAW_I[7:0]};
    wire [31:0] load_half = LOAD_SIGNED_I ? sign_extend_32(LOAD_RAW_I, 5'h0f) : {16'h0000, LOAD_RAW_I[15:0]};
    assign LOAD_DATA_O = (MEM_SIZE_I == crfp_pkg::SIZE_BYTE) ? load_byte :
                         (MEM_SIZE_I == crfp_pkg::SIZE_HALF) ? load_half : LOAD_RAW_I;
    assign SIGN_EXTEND_32_O = sign_extend_32(SEXT_ARG_I, SEXT_MSB_I);
    assign FIELD_READ_O = FIELD_VAL_I & ~READ_AS_ZERO_FIELD_MASK_I;

    crfp_primitives u_prims (
        .shift_val_i(SHIFT_VAL_I),
        .shift_amt_i(SHIFT_AMT_I),
        .shift_op_i(SHIFT_OP_I),
        .ovf_a_i(OVF_A_I),
        .ovf_b_i(OVF_B_I),
        .ovf_res_i(OVF_RES_I),
        .ovf_sub_i(OVF_SUB_I),
        .pop_field_i(POP_FIELD_I),
        .shift_res_o(SHIFT_RES_O),
        .ovf_o(SIGNED_OVERFLOW_DETECT_O),
        .pop_count_o(POPULATION_COUNT_O)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SRST_I);

    sequence s_step_bl;
        STEP_I && BRANCH_WITH_LINK_I && !exc_ok;
    endsequence

    a_pc_low_zero: assert property (PROGRAM_COUNTER_O[1:0] == 2'b00)
        else $error("program counter low bits not zero");
    a_pc_read_ahead: assert property ((RD_A_SEL_I == crfp_pkg::REG_PC) |-> RD_A_DATA_O == PROGRAM_COUNTER_O + 32'h8)
        else $error("pc read not eight ahead");
    a_link_capture: assert property (s_step_bl ##1 (RD_A_SEL_I == crfp_pkg::REG_LINK && MODE_O == $past(MODE_O))
        |-> RD_A_DATA_O == $past(PROGRAM_COUNTER_O) + 32'h4)
        else $error("link register missed return address");
    a_user_locked: assert property ((MODE_O == crfp_pkg::CRFP_MODE_USER && STEP_I && !EXC_TAKE_I)
        |=> MODE_O == crfp_pkg::CRFP_MODE_USER)
        else $error("user mode left without exception");
    a_saved_status: assert property (MODE_HAS_SAVED_STATUS_O == (MODE_O != 5'h10 && MODE_O != 5'h1f))
        else $error("saved status predicate wrong");
    a_privileged: assert property (IS_PRIVILEGED_MODE_O == (MODE_O != 5'h10))
        else $error("privilege predicate wrong");
    a_word_align: assert property ((MEM_SIZE_I == 3'h4) |-> MEM_ADDR_ALIGNED_O[1:0] == 2'b00)
        else $error("word address not aligned");
    a_zero_extend: assert property ((MEM_SIZE_I == 3'h1 && !LOAD_SIGNED_I) |-> LOAD_DATA_O[31:8] == 24'h0)
        else $error("byte load not zero extended");
    a_raz_field: assert property (((FIELD_READ_O & READ_AS_ZERO_FIELD_MASK_I) == 32'h0))
        else $error("read as zero field nonzero");
    a_pc_advance: assert property ((STEP_I && !exc_ok && !BRANCH_TAKEN_I && !wr_to_pc)
        |=> PROGRAM_COUNTER_O == $past(PROGRAM_COUNTER_O) + 32'h4)
        else $error("program counter did not advance");
endmodule

// file: sim/crfp_dp_model.sv
// Purpose: Behavioural decode/execute datapath that issues commit requests
// Assumes: One request per call; STEP_I high for exactly one sampling edge
// Notes: Every field returns to zero after a commit so no stale request is taken
`timescale 1ns/10ps
module crfp_dp_model (
    input wire logic clk_i,
    output logic step_o,
    output logic wr_en_o,
    output logic [3:0] wr_sel_o,
    output logic [31:0] wr_data_o,
    output logic bl_o,
    output logic bt_o,
    output logic [31:0] tgt_o,
    output logic mode_wr_o,
    output logic [4:0] mode_o,
    output logic exc_o
);
    initial {step_o, wr_en_o, wr_sel_o, wr_data_o, bl_o, bt_o, tgt_o, mode_wr_o, mode_o, exc_o} = '0;

    ////////////////////////////////////////////////////////////////////////////////
    // Fields are set at one edge, taken at the next, then cleared
    task automatic commit();
        step_o <= 1'b1;
        @(posedge clk_i);
        {step_o, wr_en_o, wr_sel_o, wr_data_o, bl_o, bt_o, tgt_o, mode_wr_o, mode_o, exc_o} <= '0;
    endtask

    task automatic wr(input logic [3:0] s, input logic [31:0] d);
        @(posedge clk_i);
        wr_en_o <= 1'b1;
        wr_sel_o <= s;
        wr_data_o <= d;
        commit();
    endtask

    task automatic bl(input logic [31:0] t);
        @(posedge clk_i);
        bl_o <= 1'b1;
        bt_o <= 1'b1;
        tgt_o <= t;
        commit();
    endtask

    task automatic mode(input logic [4:0] m);
        @(posedge clk_i);
        mode_wr_o <= 1'b1;
        mode_o <= m;
        commit();
    endtask

    // Vector shares the target lines; branch stays low so only the entry acts
    task automatic exc(input logic [4:0] m, input logic [31:0] v);
        @(posedge clk_i);
        exc_o <= 1'b1;
        mode_o <= m;
        tgt_o <= v;
        commit();
    endtask
endmodule

// file: sim/crfp_core_tb.sv
// Purpose: Self-checking bench for the banked register file and its primitives
// Assumes: Datapath model issues commits; bench drives reads and primitives
// Notes: Steps are spaced two cycles apart, which the core accepts
`timescale 1ns/10ps
module crfp_core_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] sa = '0, sb = '0;
    logic [31:0] ra, rb, pc, maddr = '0, mal, raw = '0, ld, sarg = '0, sx, fv = '0, fm = '0, fr;
    logic [31:0] sv = '0, shr, oa = '0, ob = '0, ores = '0, pf = '0;
    logic [4:0] md, smsb = '0, samt = '0;
    logic [2:0] msz = 3'h4;
    logic [1:0] sop = '0;
    logic lsg = 1'b0, osub = 1'b0, hss, prv, ovf;
    logic [5:0] pop;
    logic step, we, bl, bt, mw, ex;
    logic [3:0] ws;
    logic [31:0] wd, tg;
    logic [4:0] mn;
    int num_errors = 0;
    int samples_checked = 0;
    logic [4:0] ml [6] = '{5'h12, 5'h13, 5'h17, 5'h1b, 5'h1f, 5'h10};

    initial forever #5 clk = ~clk;

    crfp_dp_model dp (.clk_i(clk), .step_o(step), .wr_en_o(we), .wr_sel_o(ws), .wr_data_o(wd), .bl_o(bl),
        .bt_o(bt), .tgt_o(tg), .mode_wr_o(mw), .mode_o(mn), .exc_o(ex));

    crfp_core dut (.CORE_CLK_I(clk), .SRST_I(srst), .STEP_I(step), .RD_A_SEL_I(sa), .RD_B_SEL_I(sb),
        .RD_A_DATA_O(ra), .RD_B_DATA_O(rb), .WR_EN_I(we), .WR_SEL_I(ws), .WR_DATA_I(wd),
        .BRANCH_WITH_LINK_I(bl), .BRANCH_TAKEN_I(bt), .BRANCH_TARGET_I(tg), .MODE_WR_I(mw), .MODE_NEW_I(mn),
        .EXC_TAKE_I(ex), .EXC_MODE_I(mn), .EXC_VECTOR_I(tg), .PROGRAM_COUNTER_O(pc), .MODE_O(md),
        .MODE_HAS_SAVED_STATUS_O(hss), .IS_PRIVILEGED_MODE_O(prv), .MEM_ADDR_I(maddr), .MEM_SIZE_I(msz),
        .MEM_ADDR_ALIGNED_O(mal), .LOAD_RAW_I(raw), .LOAD_SIGNED_I(lsg), .LOAD_DATA_O(ld), .SEXT_ARG_I(sarg),
        .SEXT_MSB_I(smsb), .SIGN_EXTEND_32_O(sx), .FIELD_VAL_I(fv), .READ_AS_ZERO_FIELD_MASK_I(fm),
        .FIELD_READ_O(fr), .SHIFT_VAL_I(sv), .SHIFT_AMT_I(samt), .SHIFT_OP_I(sop), .SHIFT_RES_O(shr),
        .OVF_A_I(oa), .OVF_B_I(ob), .OVF_RES_I(ores), .OVF_SUB_I(osub), .SIGNED_OVERFLOW_DETECT_O(ovf),
        .POP_FIELD_I(pf), .POPULATION_COUNT_O(pop));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
        end
    endtask

    // Both ports read the same specifier so each is seen reaching every register
    task automatic rd(input logic [3:0] s, input logic [31:0] exp);
        @(posedge clk);
        sa <= s;
        sb <= s;
        #1;
        chk(ra, exp);
        chk(rb, exp);
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        for (int i = 0; i < 15; i++) dp.wr(4'(i), 32'h1000_0000 + 32'(i));
        for (int i = 0; i < 15; i++) rd(4'(i), 32'h1000_0000 + 32'(i));
        rd(4'hf, 32'h0000_0044);
        dp.wr(4'hf, 32'h0000_0203);
        #1;
        chk(pc, 32'h0000_0200);
        rd(4'hf, 32'h0000_0208);
        rd(4'he, 32'h1000_000e);
        dp.bl(32'h0000_0400);
        #1;
        chk(pc, 32'h0000_0400);
        rd(4'he, 32'h0000_0204);
    endtask

    task automatic t_bank();
        dp.mode(5'h11);
        for (int i = 8; i < 15; i++) dp.wr(4'(i), 32'h2000_0000 + 32'(i));
        rd(4'h8, 32'h2000_0008);
        dp.mode(5'h1f);
        rd(4'hc, 32'h1000_000c);
        dp.wr(4'hd, 32'h3000_000d);
        dp.mode(5'h13);
        rd(4'hd, 32'h1000_000d);
        rd(4'he, 32'h0000_0204);
        dp.mode(5'h11);
        rd(4'he, 32'h2000_000e);
        foreach (ml[i]) begin
            dp.mode(ml[i]);
            #1;
            chk({27'h0, md}, {27'h0, ml[i]});
            chk({31'h0, hss}, {31'h0, ml[i] != 5'h10 && ml[i] != 5'h1f});
            chk({31'h0, prv}, {31'h0, ml[i] != 5'h10});
        end
        rd(4'hd, 32'h3000_000d);
        dp.mode(5'h13);
        #1;
        chk({27'h0, md}, 32'h0000_0010);
        dp.exc(5'h12, 32'h0000_0018);
        #1;
        chk({27'h0, md}, 32'h0000_0012);
        chk(pc, 32'h0000_0018);
        dp.wr(4'hd, 32'h4000_000d);
        rd(4'hd, 32'h4000_000d);
        dp.mode(5'h11);
        rd(4'hd, 32'h2000_000d);
        rd(4'he, 32'h2000_000e);
    endtask

    // Primitive inputs change at the edge; outputs are read once settled
    task automatic t_prims();
        logic [31:0] sh_exp [4] = '{32'h0000_0010, 32'h0800_0000, 32'hf800_0000, 32'h1800_0000};
        @(posedge clk);
        maddr <= 32'h1234_5677;
        raw <= 32'h0000_8080;
        msz <= 3'h1;
        #1;
        chk(mal, 32'h1234_5677);
        chk(ld, 32'h0000_0080);
        @(posedge clk);
        msz <= 3'h2;
        lsg <= 1'b1;
        sarg <= 32'h0000_0080;
        smsb <= 5'h07;
        fv <= 32'hffff_ffff;
        fm <= 32'h0000_ff00;
        #1;
        chk(mal, 32'h1234_5676);
        chk(ld, 32'hffff_8080);
        chk(sx, 32'hffff_ff80);
        chk(fr, 32'hffff_00ff);
        @(posedge clk);
        msz <= 3'h4;
        sarg <= 32'h0000_7fff;
        smsb <= 5'h0f;
        #1;
        chk(mal, 32'h1234_5674);
        chk(sx, 32'h0000_7fff);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            sv <= 32'h8000_0001;
            samt <= 5'h04;
            sop <= 2'(i);
            #1;
            chk(shr, sh_exp[i]);
        end
        @(posedge clk);
        oa <= 32'h7fff_ffff;
        ob <= 32'h0000_0001;
        ores <= 32'h8000_0000;
        pf <= 32'hf0f0_0001;
        #1;
        chk({31'h0, ovf}, 32'h1);
        chk({26'h0, pop}, 32'h9);
        @(posedge clk);
        osub <= 1'b1;
        oa <= 32'h8000_0000;
        ores <= 32'h7fff_ffff;
        pf <= 32'hffff_ffff;
        #1;
        chk({31'h0, ovf}, 32'h1);
        chk({26'h0, pop}, 32'h20);
        @(posedge clk);
        oa <= 32'h0000_0001;
        ores <= 32'h0000_0000;
        #1;
        chk({31'h0, ovf}, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        num_errors++;
        summarize();
    end

    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk(pc, 32'h0);
        chk({27'h0, md}, 32'h0000_0013);
        t_regs();
        t_bank();
        t_prims();
        summarize();
    end
endmodule
